// *** rtl/egd_ctrl.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "egd_consts.svh"

// Behaviour
// - Dark loop targets average 64, default zero
// - Dark loop reuses black calculation on corrected data
// - Setup bit 2 selects all or half lines
// - Half mode uses lines preceded by dark
// - Black and dark modes chosen independently
// - Integration equals coarse times line plus fine
// - Pixel clock divides by basic times divisor
// - Clip coarse and fine to current limits
// - Fine offsets 51, 86, 51, 23 per mode
// - Gain nibbles: upper capacitive, lower current
// - Mode bit1 set: igain inverts nibble
// - Mode bit1 clear: invert bit-reversed nibble
// - Ten-bit cgain: nibble then two ones
// - Nine-bit cgain: halved nibble then ones
// - PAL/NTSC nine-bit, CIF/QCIF ten-bit mapping
// - Gain lands one frame after exposure
// - Exposure shadowed, coarse moved at field points, fine at last line of odd field, pending
module egd_ctrl
  import egd_pkg::*;
#(
  parameter int DARK_LINES = 8,
  parameter int AVG_LOG2   = 6
)(
  input  wire logic        i_mclk,
  input  wire logic        i_nrst,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [7:0]  i_reg_wdata,
  output logic      [7:0]  o_reg_rdata,
  input  wire logic [9:0]  i_pix_data,
  output logic             o_pix_tick,
  output logic             o_dark_use,
  output logic      [11:0] o_dark_offset,
  output egd_cancel_e      o_black_mode,
  output egd_cancel_e      o_dark_mode,
  output logic      [15:0] o_coarse_exp,
  output logic      [15:0] o_fine_exp,
  output logic      [31:0] o_integ_pck,
  output egd_gain_s        o_gain_codes,
  output logic             o_adc_10bit
);

  localparam int ACC_W = 10 + AVG_LOG2;

  // Register file
  logic [7:0]  setup0_q;
  logic [7:0]  modesel_q;
  logic [7:0]  gain_sh_q;
  logic [7:0]  gain_wk_q;
  logic [3:0]  pixdiv_q;
  logic [7:0]  dark_ext_q;
  logic [7:0]  black_setup_q;
  logic [7:0]  dark_setup_q;
  logic [15:0] fine_sh_q;
  logic [15:0] coarse_sh_q;
  logic [15:0] fine_wk_q;
  logic [15:0] coarse_wk_q;
  logic [15:0] line_sh_q;
  logic [15:0] field_sh_q;
  logic [15:0] line_wk_q;
  logic [15:0] field_wk_q;
  logic        fine_pend_q;
  logic        coarse_pend_q;
  logic        gain_pend_q;
  logic        gain_arm_q;
  logic        timing_pend_q;
  logic        line_pend_q;

  egd_mode_e   mode;
  logic        wr_fine;
  logic        wr_coarse;
  logic        wr_gain;
  logic        wr_timing;
  logic        wr_line;

  assign mode      = egd_mode_e'(setup0_q[1:0]);
  assign wr_fine   = i_reg_wr && (i_reg_addr == `EGD_ADDR_FINE_HI ||
                                  i_reg_addr == `EGD_ADDR_FINE_LO);
  assign wr_coarse = i_reg_wr && (i_reg_addr == `EGD_ADDR_COARSE_HI ||
                                  i_reg_addr == `EGD_ADDR_COARSE_LO);
  assign wr_gain   = i_reg_wr && i_reg_addr == `EGD_ADDR_GAIN;
  assign wr_line   = i_reg_wr && (i_reg_addr == `EGD_ADDR_LINE_HI ||
                                  i_reg_addr == `EGD_ADDR_LINE_LO);
  assign wr_timing = wr_line || (i_reg_wr && (i_reg_addr == `EGD_ADDR_FIELD_HI ||
                                              i_reg_addr == `EGD_ADDR_FIELD_LO));

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      setup0_q      <= `EGD_RST_BYTE;
      modesel_q     <= `EGD_RST_BYTE;
      gain_sh_q     <= `EGD_RST_GAIN;
      pixdiv_q      <= 4'h0;
      dark_ext_q    <= `EGD_RST_BYTE;
      black_setup_q <= `EGD_RST_BYTE;
      dark_setup_q  <= `EGD_RST_BYTE;
      fine_sh_q     <= `EGD_RST_WORD;
      coarse_sh_q   <= `EGD_RST_WORD;
      line_sh_q     <= `EGD_RST_LINE;
      field_sh_q    <= `EGD_RST_FIELD;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        `EGD_ADDR_SETUP0:      setup0_q          <= i_reg_wdata;
        `EGD_ADDR_MODESEL:     modesel_q         <= i_reg_wdata;
        `EGD_ADDR_GAIN:        gain_sh_q         <= i_reg_wdata;
        `EGD_ADDR_CLKDIV:      pixdiv_q          <= i_reg_wdata[3:0];
        `EGD_ADDR_DARK_EXT:    dark_ext_q        <= i_reg_wdata;
        `EGD_ADDR_BLACK_SETUP: black_setup_q     <= i_reg_wdata;
        `EGD_ADDR_DARK_SETUP:  dark_setup_q      <= i_reg_wdata;
        `EGD_ADDR_FINE_HI:     fine_sh_q[15:8]   <= i_reg_wdata;
        `EGD_ADDR_FINE_LO:     fine_sh_q[7:0]    <= i_reg_wdata;
        `EGD_ADDR_COARSE_HI:   coarse_sh_q[15:8] <= i_reg_wdata;
        `EGD_ADDR_COARSE_LO:   coarse_sh_q[7:0]  <= i_reg_wdata;
        `EGD_ADDR_LINE_HI:     line_sh_q[15:8]   <= i_reg_wdata;
        `EGD_ADDR_LINE_LO:     line_sh_q[7:0]    <= i_reg_wdata;
        `EGD_ADDR_FIELD_HI:    field_sh_q[15:8]  <= i_reg_wdata;
        `EGD_ADDR_FIELD_LO:    field_sh_q[7:0]   <= i_reg_wdata;
        default:               setup0_q          <= setup0_q;
      endcase
    end
  end

  // Pixel clock divider
  logic [7:0] bdiv;
  logic [7:0] div_total;
  logic [7:0] div_cnt_q;
  logic       pix_tick;

  always_comb begin
    case (mode)
      EGD_CIF:  bdiv = `EGD_BDIV_CIF;
      EGD_QCIF: bdiv = `EGD_BDIV_QCIF;
      default:  bdiv = `EGD_BDIV_TV;
    endcase
  end

  // A divisor of zero is taken as one so the tick never stops
  assign div_total = 8'(bdiv * ((pixdiv_q == 4'h0) ? 8'h01 : {4'h0, pixdiv_q}));
  assign pix_tick  = div_cnt_q >= div_total - 8'h01;
  assign o_pix_tick = pix_tick;

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      div_cnt_q <= 8'h00;
    end else if (pix_tick) begin
      div_cnt_q <= 8'h00;
    end else begin
      div_cnt_q <= div_cnt_q + 8'h01;
    end
  end

  // Line and field timing in pixel clocks
  logic [15:0] pix_cnt_q;
  logic [15:0] line_cnt_q;
  logic        odd_q;
  logic        line_end;
  logic        field_end;

  assign line_end  = pix_tick && pix_cnt_q >= line_wk_q - 16'h0001;
  assign field_end = line_end && line_cnt_q >= field_wk_q - 16'h0001;

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      pix_cnt_q  <= 16'h0000;
      line_cnt_q <= 16'h0000;
      odd_q      <= 1'b1;
    end else if (field_end) begin
      pix_cnt_q  <= 16'h0000;
      line_cnt_q <= 16'h0000;
      odd_q      <= ~odd_q;
    end else if (line_end) begin
      pix_cnt_q  <= 16'h0000;
      line_cnt_q <= line_cnt_q + 16'h0001;
    end else if (pix_tick) begin
      pix_cnt_q  <= pix_cnt_q + 16'h0001;
    end
  end

  // Update points: coarse at the first dark line of an odd field
  logic coarse_pt;
  logic fine_pt;
  logic timing_pt;

  assign coarse_pt = field_end && !odd_q;
  assign timing_pt = field_end && odd_q;
  assign fine_pt   = line_pend_q ? timing_pt :
                     (line_end && odd_q && line_cnt_q == field_wk_q - 16'h0002);

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      line_wk_q     <= `EGD_RST_LINE;
      field_wk_q    <= `EGD_RST_FIELD;
      timing_pend_q <= 1'b0;
      line_pend_q   <= 1'b0;
    end else begin
      if (timing_pt) begin
        line_wk_q  <= line_sh_q;
        field_wk_q <= field_sh_q;
      end
      // A write in the transfer cycle keeps its flag raised
      timing_pend_q <= wr_timing ? 1'b1 : (timing_pt ? 1'b0 : timing_pend_q);
      line_pend_q   <= wr_line ? 1'b1 : (timing_pt ? 1'b0 : line_pend_q);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      fine_wk_q     <= `EGD_RST_WORD;
      coarse_wk_q   <= `EGD_RST_WORD;
      fine_pend_q   <= 1'b0;
      coarse_pend_q <= 1'b0;
    end else begin
      if (fine_pt) begin
        fine_wk_q <= fine_sh_q;
      end
      if (coarse_pt) begin
        coarse_wk_q <= coarse_sh_q;
      end
      fine_pend_q   <= wr_fine ? 1'b1 : (fine_pt ? 1'b0 : fine_pend_q);
      coarse_pend_q <= wr_coarse ? 1'b1 : (coarse_pt ? 1'b0 : coarse_pend_q);
    end
  end

  // Gain waits one frame behind the exposure it matches
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      gain_wk_q   <= `EGD_RST_GAIN;
      gain_pend_q <= 1'b0;
      gain_arm_q  <= 1'b0;
    end else begin
      if (coarse_pt && gain_arm_q) begin
        gain_wk_q  <= gain_sh_q;
        gain_arm_q <= 1'b0;
      end else if (coarse_pt && gain_pend_q) begin
        gain_arm_q <= 1'b1;
      end
      gain_pend_q <= wr_gain ? 1'b1 : ((coarse_pt && gain_arm_q) ? 1'b0 : gain_pend_q);
    end
  end

  // Clip limits follow the working lengths and the mode every cycle
  logic [15:0] fofs;
  logic [15:0] coarse_max_q;
  logic [15:0] fine_max_q;
  logic [15:0] coarse_app;
  logic [15:0] fine_app;

  always_comb begin
    case (mode)
      EGD_NTSC: fofs = `EGD_FOFS_NTSC;
      EGD_PAL:  fofs = `EGD_FOFS_PAL;
      EGD_CIF:  fofs = `EGD_FOFS_CIF;
      EGD_QCIF: fofs = `EGD_FOFS_QCIF;
      default:  fofs = `EGD_FOFS_CIF;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      coarse_max_q <= `EGD_RST_WORD;
      fine_max_q   <= `EGD_RST_WORD;
    end else begin
      coarse_max_q <= field_wk_q - 16'h0001;
      fine_max_q   <= (line_wk_q > fofs) ? line_wk_q - fofs : 16'h0000;
    end
  end

  assign coarse_app = (coarse_wk_q > coarse_max_q) ? coarse_max_q : coarse_wk_q;
  assign fine_app   = (fine_wk_q > fine_max_q) ? fine_max_q : fine_wk_q;

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      o_coarse_exp <= `EGD_RST_WORD;
      o_fine_exp   <= `EGD_RST_WORD;
      o_integ_pck  <= 32'h0000_0000;
    end else begin
      o_coarse_exp <= coarse_app;
      o_fine_exp   <= fine_app;
      o_integ_pck  <= coarse_app * line_wk_q + {16'h0000, fine_app};
    end
  end

  // Dark line selection and averaging
  logic              in_dark;
  logic              dark_use;
  logic [ACC_W-1:0]  acc_q;
  logic [AVG_LOG2:0] n_q;
  logic [12:0]       avg;
  logic signed [12:0] err;
  logic [12:0]       band;
  logic [2:0]        shift;
  logic signed [11:0] dark_off_q;

  assign in_dark  = line_cnt_q < 16'(DARK_LINES);
  // Odd-numbered dark lines always have a dark line above them
  assign dark_use = in_dark && (!dark_setup_q[`EGD_SETUP_HALF_BIT] || line_cnt_q[0]);
  assign avg      = 13'(acc_q >> AVG_LOG2);
  assign err      = $signed(avg) - $signed(`EGD_DARK_TARGET);
  assign band     = dark_setup_q[`EGD_SETUP_BAND_BIT] ? `EGD_BAND_WIDE : `EGD_BAND_NARROW;
  assign shift    = dark_setup_q[`EGD_SETUP_SHIFT_MSB:`EGD_SETUP_SHIFT_LSB];
  assign o_dark_mode  = egd_cancel_e'(dark_setup_q[1:0]);
  assign o_black_mode = egd_cancel_e'(black_setup_q[1:0]);

  // Input pixels are taken as already black corrected
  always_ff @(posedge i_mclk) begin
    if (!i_nrst || field_end) begin
      acc_q <= '0;
      n_q   <= '0;
    end else if (pix_tick && dark_use && !n_q[AVG_LOG2]) begin
      acc_q <= acc_q + ACC_W'(i_pix_data);
      n_q   <= n_q + 1'b1;
    end
  end

  // Same leaky step and dead band as the black loop
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      dark_off_q <= 12'sh000;
    end else if (field_end && o_dark_mode == EGD_CANCEL_INT && n_q[AVG_LOG2]) begin
      if (err > $signed(band) || err < -$signed(band)) begin
        dark_off_q <= dark_off_q - 12'(err >>> shift);
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      o_dark_offset <= 12'h000;
      o_dark_use    <= 1'b0;
    end else begin
      o_dark_use <= dark_use;
      case (o_dark_mode)
        EGD_CANCEL_INT: o_dark_offset <= dark_off_q;
        EGD_CANCEL_EXT: o_dark_offset <= {{4{dark_ext_q[7]}}, dark_ext_q};
        default:        o_dark_offset <= 12'h000;
      endcase
    end
  end

  // Gain decode on the working value
  egd_gain_s gain_codes;
  logic      adc10;

  assign adc10 = (mode == EGD_CIF) || (mode == EGD_QCIF);

  egd_gain_decode u_gain_decode (
    .i_gain      (gain_wk_q),
    .i_inv_only  (modesel_q[`EGD_MODESEL_INV_BIT]),
    .i_adc_10bit (adc10),
    .o_codes     (gain_codes)
  );

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      o_gain_codes <= '0;
      o_adc_10bit  <= 1'b0;
    end else begin
      o_gain_codes <= gain_codes;
      o_adc_10bit  <= adc10;
    end
  end

  // Read back, one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        `EGD_ADDR_STATUS0:     o_reg_rdata <= {3'b000, timing_pend_q, gain_pend_q,
                                               coarse_pend_q, fine_pend_q, 1'b0};
        `EGD_ADDR_SETUP0:      o_reg_rdata <= setup0_q;
        `EGD_ADDR_MODESEL:     o_reg_rdata <= modesel_q;
        `EGD_ADDR_FINE_HI:     o_reg_rdata <= fine_sh_q[15:8];
        `EGD_ADDR_FINE_LO:     o_reg_rdata <= fine_sh_q[7:0];
        `EGD_ADDR_COARSE_HI:   o_reg_rdata <= coarse_sh_q[15:8];
        `EGD_ADDR_COARSE_LO:   o_reg_rdata <= coarse_sh_q[7:0];
        `EGD_ADDR_GAIN:        o_reg_rdata <= gain_sh_q;
        `EGD_ADDR_CLKDIV:      o_reg_rdata <= {bdiv[3:0], pixdiv_q};
        `EGD_ADDR_DARK_EXT:    o_reg_rdata <= dark_ext_q;
        `EGD_ADDR_BLACK_SETUP: o_reg_rdata <= black_setup_q;
        `EGD_ADDR_DARK_SETUP:  o_reg_rdata <= dark_setup_q;
        `EGD_ADDR_LINE_HI:     o_reg_rdata <= line_sh_q[15:8];
        `EGD_ADDR_LINE_LO:     o_reg_rdata <= line_sh_q[7:0];
        `EGD_ADDR_FIELD_HI:    o_reg_rdata <= field_sh_q[15:8];
        `EGD_ADDR_FIELD_LO:    o_reg_rdata <= field_sh_q[7:0];
        default:               o_reg_rdata <= 8'h00;
      endcase
    end
  end

endmodule // egd_ctrl

`default_nettype wire

// *** inc/egd_consts.svh ***
`ifndef EGD_CONSTS_SVH
`define EGD_CONSTS_SVH

// Register offsets
`define EGD_ADDR_STATUS0     8'h02
`define EGD_ADDR_SETUP0      8'h10
`define EGD_ADDR_MODESEL     8'h18
`define EGD_ADDR_FINE_HI     8'h20
`define EGD_ADDR_FINE_LO     8'h21
`define EGD_ADDR_COARSE_HI   8'h22
`define EGD_ADDR_COARSE_LO   8'h23
`define EGD_ADDR_GAIN        8'h24
`define EGD_ADDR_CLKDIV      8'h25
`define EGD_ADDR_DARK_EXT    8'h2c
`define EGD_ADDR_BLACK_SETUP 8'h2d
`define EGD_ADDR_DARK_SETUP  8'h2e
`define EGD_ADDR_LINE_HI     8'h52
`define EGD_ADDR_LINE_LO     8'h53
`define EGD_ADDR_FIELD_HI    8'h61
`define EGD_ADDR_FIELD_LO    8'h62

// Reset values
`define EGD_RST_BYTE         8'h00
`define EGD_RST_GAIN         8'hfe
`define EGD_RST_WORD         16'h0000
`define EGD_RST_LINE         16'h0100
`define EGD_RST_FIELD        16'h0040

// Field positions
`define EGD_MODESEL_INV_BIT  1
`define EGD_SETUP_HALF_BIT   2
`define EGD_SETUP_BAND_BIT   3
`define EGD_SETUP_SHIFT_LSB  4
`define EGD_SETUP_SHIFT_MSB  6

// Fine exposure offsets in pixel clocks
`define EGD_FOFS_NTSC        16'h0033
`define EGD_FOFS_PAL         16'h0056
`define EGD_FOFS_CIF         16'h0033
`define EGD_FOFS_QCIF        16'h0017

// Basic system clock division
`define EGD_BDIV_TV          8'h02
`define EGD_BDIV_CIF         8'h04
`define EGD_BDIV_QCIF        8'h08

// Dark loop target and dead bands
`define EGD_DARK_TARGET      13'h0040
`define EGD_BAND_NARROW      13'h0002
`define EGD_BAND_WIDE        13'h0004

`endif

// *** inc/egd_pkg.sv ***
package egd_pkg;

  typedef enum logic [1:0] {
    EGD_NTSC,
    EGD_PAL,
    EGD_CIF,
    EGD_QCIF
  } egd_mode_e;

  typedef enum logic [1:0] {
    EGD_CANCEL_OFF,
    EGD_CANCEL_INT,
    EGD_CANCEL_EXT,
    EGD_CANCEL_RSVD
  } egd_cancel_e;

  typedef struct packed {
    logic [3:0] igain;
    logic [5:0] cgain;
  } egd_gain_s;

endpackage

// *** rtl/egd_gain_decode.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "egd_consts.svh"

module egd_gain_decode
  import egd_pkg::*;
(
  input  wire logic [7:0] i_gain,
  input  wire logic       i_inv_only,
  input  wire logic       i_adc_10bit,
  output egd_gain_s       o_codes
);

  logic [3:0] ls_nib;
  logic [3:0] ms_nib;

  assign ls_nib = i_gain[3:0];
  assign ms_nib = i_gain[7:4];

  always_comb begin
    if (i_inv_only) begin
      o_codes.igain = ~ls_nib;
    end else begin
      o_codes.igain = ~{ls_nib[0], ls_nib[1], ls_nib[2], ls_nib[3]};
    end
    if (i_adc_10bit) begin
      o_codes.cgain = {ms_nib, 2'b11};
    end else begin
      o_codes.cgain = {1'b0, ms_nib[3:1], 2'b11};
    end
  end

endmodule // egd_gain_decode

`default_nettype wire

// *** bench/egd_ctrl_props.sv ***
`timescale 1ns/100ps
`default_nettype none
module egd_ctrl_props
  import egd_pkg::*;
(
  input wire logic        i_mclk,
  input wire logic        i_nrst,
  input wire logic        i_reg_wr,
  input wire logic        i_reg_rd,
  input wire logic [7:0]  i_reg_addr,
  input wire logic [7:0]  i_reg_wdata,
  input wire logic [7:0]  o_reg_rdata,
  input wire logic        o_pix_tick,
  input wire logic        o_dark_use,
  input wire logic [15:0] o_coarse_exp,
  input wire logic [15:0] o_fine_exp,
  input wire logic [31:0] o_integ_pck,
  input wire egd_gain_s   o_gain_codes,
  input wire logic        o_adc_10bit
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_nrst);

  a_gain_readback: assert property (
    (i_reg_wr && i_reg_addr == 8'h24) ##1 !i_reg_wr ##1 (i_reg_rd && i_reg_addr == 8'h24)
    |=> o_reg_rdata == $past(i_reg_wdata, 3)) else $error("gain read back wrong");
  a_gain_pending: assert property (
    (i_reg_wr && i_reg_addr == 8'h24) ##1 !i_reg_wr ##1 (i_reg_rd && i_reg_addr == 8'h02)
    |=> o_reg_rdata[3]) else $error("gain pending flag missing");
  a_rdata_holds: assert property (!$past(i_reg_rd) |-> $stable(o_reg_rdata))
    else $error("read data moved without a read");
  a_cgain_low_ones: assert property ($past(i_nrst) |-> o_gain_codes.cgain[1:0] == 2'b11)
    else $error("cap code low bits not ones");
  a_cgain_nine_bit: assert property (
    !o_adc_10bit && !$past(o_adc_10bit) && $past(i_nrst) |-> !o_gain_codes.cgain[5])
    else $error("nine-bit cap code top bit set");
  a_igain_nonzero: assert property ($past(i_nrst) |-> o_gain_codes.igain != 4'h0)
    else $error("current gain code zero");
  a_tick_single: assert property (o_pix_tick |=> !o_pix_tick)
    else $error("pixel tick longer than one cycle");
  a_tick_bound: assert property (o_pix_tick |-> ##[1:120] o_pix_tick)
    else $error("pixel tick gap too long");
  a_integ_fine: assert property (
    o_coarse_exp == 16'h0000 && $stable(o_coarse_exp) && $stable(o_fine_exp)
    |-> o_integ_pck == {16'h0000, o_fine_exp}) else $error("integration without coarse wrong");

  c_dark_lines: cover property ($rose(o_dark_use));
  c_ten_bit: cover property ($rose(o_adc_10bit));
  c_unmapped: cover property (i_reg_rd && i_reg_addr == 8'h7f);
endmodule // egd_ctrl_props

bind egd_ctrl egd_ctrl_props u_props (
  .i_mclk       (i_mclk),
  .i_nrst       (i_nrst),
  .i_reg_wr     (i_reg_wr),
  .i_reg_rd     (i_reg_rd),
  .i_reg_addr   (i_reg_addr),
  .i_reg_wdata  (i_reg_wdata),
  .o_reg_rdata  (o_reg_rdata),
  .o_pix_tick   (o_pix_tick),
  .o_dark_use   (o_dark_use),
  .o_coarse_exp (o_coarse_exp),
  .o_fine_exp   (o_fine_exp),
  .o_integ_pck  (o_integ_pck),
  .o_gain_codes (o_gain_codes),
  .o_adc_10bit  (o_adc_10bit)
);
`default_nettype wire

// *** bench/egd_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module egd_host_model (
  input  wire logic       i_mclk,
  input  wire logic [7:0] i_rdata,
  output logic            o_wr,
  output logic            o_rd,
  output logic      [7:0] o_addr,
  output logic      [7:0] o_wdata
);
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end

  // Released lines show the inverse so a stale value is never mistaken for a live one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    o_wr <= 1'b1;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_mclk);
    o_wr <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask

  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    wr(a, v[15:8]);
    wr(a + 8'h01, v[7:0]);
  endtask

  // Upper nibble left all ones unless a scenario asks otherwise
  task automatic set_gain(input logic [3:0] cur, input logic [3:0] cap = 4'hf);
    wr(8'h24, {cap, (cur > 4'hc) ? 4'hc : cur});
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge i_mclk);
    o_rd <= 1'b1;
    o_addr <= a;
    @(posedge i_mclk);
    o_rd <= 1'b0;
    o_addr <= ~a;
    @(posedge i_mclk);
    q = i_rdata;
  endtask
endmodule // egd_host_model
`default_nettype wire

// *** bench/testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "egd_consts.svh"
module testbench
  import egd_pkg::*;
;
  logic        i_mclk;
  logic        i_nrst;
  logic [9:0]  pix;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  rdata;
  logic        tick;
  logic        dark_use;
  logic [11:0] dark_ofs;
  egd_cancel_e black_mode;
  egd_cancel_e dark_mode;
  logic [15:0] coarse;
  logic [15:0] fine;
  logic [31:0] integ;
  egd_gain_s   codes;
  logic        adc10;
  int          err_total = 0;
  int          checked = 0;
  int          cyc = 0;

  egd_ctrl #(.DARK_LINES(4), .AVG_LOG2(2)) uut (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .o_reg_rdata(rdata),
    .i_pix_data(pix), .o_pix_tick(tick), .o_dark_use(dark_use), .o_dark_offset(dark_ofs),
    .o_black_mode(black_mode), .o_dark_mode(dark_mode), .o_coarse_exp(coarse),
    .o_fine_exp(fine), .o_integ_pck(integ), .o_gain_codes(codes), .o_adc_10bit(adc10)
  );
  egd_host_model pm (
    .i_mclk(i_mclk), .i_rdata(rdata), .o_wr(reg_wr),
    .o_rd(reg_rd), .o_addr(reg_addr), .o_wdata(reg_wdata)
  );

  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("Comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Polls instead of fixed waits, since update points depend on field timing
  task automatic settle(input logic [7:0] mask);
    logic [7:0] q;
    for (int n = 0; n < 500; n++) begin
      pm.rd(`EGD_ADDR_STATUS0, q);
      if ((q & mask) == 8'h00) break;
      repeat (100) @(posedge i_mclk);
    end
    check("pending clear", q & mask, 8'h00);
    repeat (4) @(posedge i_mclk);
  endtask

  task automatic count_dark(input int exp);
    int n;
    n = 0;
    for (int t = 0; t < 1080; t++) begin
      @(posedge i_mclk iff tick);
      if (dark_use) n++;
    end
    check("dark ticks per frame", n, exp);
  endtask

  task automatic t_reset();
    logic [7:0] q;
    pm.rd(`EGD_ADDR_GAIN, q);
    check("gain reset", q, `EGD_RST_GAIN);
    pm.rd(`EGD_ADDR_MODESEL, q);
    check("mode select reset", q, 8'h00);
    pm.rd(`EGD_ADDR_DARK_SETUP, q);
    check("dark setup reset", q, 8'h00);
    pm.wr(8'h7f, 8'h5a);
    pm.rd(8'h7f, q);
    check("unmapped read", q, 8'h00);
    check("reset gain codes", codes, {4'h8, 6'h1f});
    check("dark offset default", dark_ofs, 12'h000);
    pm.wr16(`EGD_ADDR_LINE_HI, 16'h005a);
    pm.wr16(`EGD_ADDR_FIELD_HI, 16'h0006);
    pm.rd(`EGD_ADDR_STATUS0, q);
    check("timing pending", q[4], 1'b1);
    settle(8'h10);
  endtask

  task automatic t_dark();
    pm.wr(`EGD_ADDR_BLACK_SETUP, 8'h01);
    pm.wr(`EGD_ADDR_DARK_SETUP, 8'h02);
    pm.wr(`EGD_ADDR_DARK_EXT, 8'hf6);
    settle(8'h10);
    check("black mode", black_mode, EGD_CANCEL_INT);
    check("dark mode", dark_mode, EGD_CANCEL_EXT);
    check("external dark offset", dark_ofs, 12'hff6);
    pm.wr(`EGD_ADDR_DARK_SETUP, 8'h01);
    settle(8'h10);
    count_dark(720);
    check("offset at target", dark_ofs, 12'h000);
    // Past the dark lines, so no field averages a mix of two levels
    @(posedge i_mclk iff !dark_use);
    pix <= 10'h050;
    for (int n = 0; n < 20000 && dark_ofs === 12'h000; n++) begin
      @(posedge i_mclk);
    end
    check("offset one step", dark_ofs, 12'hff0);
    pix <= 10'h040;
    pm.wr(`EGD_ADDR_DARK_SETUP, 8'h05);
    settle(8'h10);
    count_dark(360);
  endtask

  task automatic t_expo();
    pm.wr16(`EGD_ADDR_FINE_HI, 16'h0010);
    settle(8'h02);
    check("integration fine only", integ, 32'h0000_0010);
    pm.wr16(`EGD_ADDR_COARSE_HI, 16'h0003);
    settle(8'h04);
    check("coarse", coarse, 16'h0003);
    check("integration", integ, 32'h0000_011e);
    pm.wr16(`EGD_ADDR_COARSE_HI, 16'h0100);
    pm.wr16(`EGD_ADDR_FINE_HI, 16'h00ff);
    settle(8'h06);
    check("coarse clip", coarse, 16'h0005);
    check("fine clip", fine, 16'h0027);
  endtask

  task automatic t_modes();
    logic [1:0]  md [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
    logic [15:0] lim [4] = '{16'h0004, 16'h0027, 16'h0043, 16'h0027};
    int          div [4] = '{2, 4, 8, 2};
    int          n;
    for (int k = 0; k < 4; k++) begin
      pm.wr(`EGD_ADDR_SETUP0, {6'h00, md[k]});
      settle(8'h10);
      check("fine limit", fine, lim[k]);
      check("integration", integ, {16'h0000, lim[k]} + 32'h0000_01c2);
      check("adc width", adc10, md[k][1]);
      check("cap code", codes.cgain, md[k][1] ? 6'h3f : 6'h1f);
      @(posedge i_mclk iff tick);
      n = 0;
      do begin
        @(posedge i_mclk);
        n++;
      end while (tick !== 1'b1);
      check("pixel tick period", n, div[k]);
    end
  endtask

  task automatic t_gain();
    logic [7:0] q;
    pm.wr16(`EGD_ADDR_COARSE_HI, 16'h0002);
    pm.set_gain(4'h4, 4'hb);
    pm.rd(`EGD_ADDR_STATUS0, q);
    check("gain pending", q[3], 1'b1);
    settle(8'h04);
    check("gain held past exposure", codes, {4'h8, 6'h1f});
    settle(8'h08);
    check("mirrored gain", codes, {4'hd, 6'h17});
    pm.wr(`EGD_ADDR_MODESEL, 8'h02);
    settle(8'h10);
    pm.set_gain(4'h6, 4'h7);
    pm.rd(`EGD_ADDR_GAIN, q);
    check("gain read back", q, 8'h76);
    settle(8'h08);
    check("inverted gain", codes, {4'h9, 6'h0f});
  endtask

  initial begin
    i_nrst = 1'b0;
    pix = 10'h040;
    repeat (16) @(posedge i_mclk);
    i_nrst <= 1'b1;
    t_reset();
    t_dark();
    t_expo();
    t_modes();
    t_gain();
    close_out();
  end

  // Ceiling sits well above the longest expected run of field waits
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_total++;
      close_out();
    end
  end
endmodule // testbench
`default_nettype wire
